//--- led_switch_pkg.sv
// Constants, field layouts and helper functions shared by the LED switch control block.
// Assumes a single 250 MHz clock; all times are converted to cycles of that clock.
package led_switch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is the index shifted by two.
  localparam logic [7:0] IDX_CUR_HIGH   = 8'h07;
  localparam logic [7:0] IDX_CUR_LOW    = 8'h08;
  localparam logic [7:0] IDX_DIRECT     = 8'h09;
  localparam logic [7:0] IDX_MEASURE    = 8'h0a;
  localparam logic [7:0] IDX_DELAY      = 8'h0b;
  localparam int         ADDR_SHIFT     = 2;
  localparam int         MIN_ADDR_W     = 6;

  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [1:0] CUR_HIGH_RESET = 2'h0;
  localparam logic [9:0] CUR_CODE_MAX   = 10'h3ff;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CUR_HIGH_MSB  = 1;
  localparam int DIRECT_MSB    = 7;
  localparam int DIRECT_LSB    = 5;
  localparam int TRIM_MSB      = 4;
  localparam int MEAS_EN_BIT   = 7;
  localparam int CAL_DIS_BIT   = 6;
  localparam int GAIN_MSB      = 5;
  localparam int GAIN_LSB      = 4;
  localparam int SEL_MSB       = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS     = 4;
  localparam int OFF_LATENCY_MIN_NS = 333;
  localparam int OFF_LATENCY_MAX_NS = 444;
  localparam logic [15:0] OFF_LATENCY_CYCLES =
    16'((OFF_LATENCY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int DELAY_BASE_NS = 333;
  localparam int DELAY_STEP_NS = 111;

  // Channel select codes for switches 4, 5 and 6; code zero leaves all off.
  localparam logic [1:0] SEL_SW4 = 2'h1;
  localparam logic [1:0] SEL_SW5 = 2'h2;
  localparam logic [1:0] SEL_SW6 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_OFF_WAIT = 3'b010,
    ST_GAP_WAIT = 3'b100
  } change_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Gap in cycles for a delay code, rounded up; code zero adds nothing.
  function automatic logic [15:0] gap_cycles(input logic [7:0] code, input int base_ns, input int step_ns);
    int ns;
    ns = base_ns + (int'(code) - 1) * step_ns;
    gap_cycles = (code == 8'h00) ? 16'h0000 : 16'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : gap_cycles

  // Bit 0 drives switch 4, bit 1 switch 5, bit 2 switch 6.
  function automatic logic [2:0] select_to_switch(input logic [1:0] sel);
    select_to_switch = (sel == SEL_SW4) ? 3'h1 :
                       (sel == SEL_SW5) ? 3'h2 :
                       (sel == SEL_SW6) ? 3'h4 : 3'h0;
  endfunction : select_to_switch

endpackage : led_switch_pkg

//--- switch_changeover.sv
// Break-before-make sequencer for LED switches 4 to 6.
// Assumes led_channel_select and the direct-mode inputs are synchronous to clk.
`timescale 1ns/1ps
module switch_changeover
  import led_switch_pkg::*;
#(
  parameter int DELAY_BASE = DELAY_BASE_NS,
  parameter int DELAY_STEP = DELAY_STEP_NS
)(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic [1:0] led_channel_select,
  input  wire logic       direct_mode_enable,
  input  wire logic [2:0] direct_bits,
  input  wire logic [7:0] delay_code,
  output logic      [2:0] switch_on,
  output logic            changeover_busy
);

  change_state_t state_q, state_d;
  logic [1:0]  sel_q;
  logic [1:0]  sel_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0]  sw_q, sw_d;
  logic        busy_q;

  wire        sel_change = (led_channel_select != sel_q);
  wire        cnt_last   = (cnt_q == 16'h0001);
  wire [15:0] gap_len    = gap_cycles(delay_code, DELAY_BASE, DELAY_STEP);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    sel_d   = led_channel_select;
    cnt_d   = cnt_q;
    sw_d    = sw_q;
    if (direct_mode_enable)
    begin
      // [RQ4] direct switch drive
      state_d = ST_IDLE;
      sw_d    = direct_bits;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (sel_change)
          begin
            state_d = ST_OFF_WAIT;
            cnt_d   = OFF_LATENCY_CYCLES;
          end
          else
          begin
            sw_d = select_to_switch(sel_q);
          end
        end
        ST_OFF_WAIT:
        begin
          // [RQ8] off then gap
          cnt_d = cnt_q - 16'h0001;
          if (cnt_last)
          begin
            sw_d    = 3'h0;
            state_d = (gap_len == 16'h0000) ? ST_IDLE : ST_GAP_WAIT;
            cnt_d   = gap_len;
          end
        end
        ST_GAP_WAIT:
        begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_last)
          begin
            state_d = ST_IDLE;
          end
        end
        default:
        begin
          state_d = ST_IDLE;
          sw_d    = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      sel_q   <= 2'h0;
      cnt_q   <= 16'h0000;
      sw_q    <= 3'h0;
      busy_q  <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      sel_q   <= sel_d;
      cnt_q   <= cnt_d;
      sw_q    <= sw_d;
      busy_q  <= (state_d != ST_IDLE);
    end
  end

  assign switch_on       = sw_q;
  // Registered from the next state, so busy tracks the sequence without a decode glitch.
  assign changeover_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  a_direct_drive: assert property (@(posedge clk) disable iff (!resetn) // [RQ4]
    (ce && direct_mode_enable) |=> (switch_on == $past(direct_bits)))
    else $error("direct mode bits not driven onto switches");

  a_break_first: assert property (@(posedge clk) disable iff (!resetn) // [RQ8]
    (ce && !direct_mode_enable && state_q == ST_OFF_WAIT && cnt_last) |=> (switch_on == 3'h0))
    else $error("switches not all off after changeover latency");

  a_off_latency: assert property (@(posedge clk) disable iff (!resetn) // [RQ8]
    (ce && !direct_mode_enable && state_q == ST_IDLE && sel_change) |=> (cnt_q == OFF_LATENCY_CYCLES))
    else $error("changeover latency count wrong");

endmodule : switch_changeover

//--- led_switch_control_regs.sv
// APB register bank for switch-6 current, direct switch control, measurement mux and changeover delay.
// Assumes an APB master on clk; led_channel_select and direct_mode_enable are synchronous to clk.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Operation
// [RQ1] Register 08h holds switch-6 current code bits 7:0, read/write, reset zero.
// [RQ2] Register 07h bits 1:0 supply current code bits 9:8, joined with low byte.
// [RQ3] Every 10-bit current code up to 3FFh is applied unclamped.
// [RQ4] In direct mode, register 09h bits 7:5 drive switches 6, 5, 4.
// [RQ5] Register 09h is read/write, resets zero, bits 4:0 are undervoltage trim.
// [RQ6] Register 0Ah: enable, calibration disable, 2-bit gain, 4-bit input select; reset zero.
// [RQ7] Register 0Bh holds the changeover delay, read/write, reset zero.
// [RQ8] On select change switches go off after 333-444 ns, then programmed delay.
// [RQ9] Writes apply at end of access; reads return the last written value.
module led_switch_control_regs
  import led_switch_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int DELAY_BASE = DELAY_BASE_NS,
  parameter int DELAY_STEP = DELAY_STEP_NS
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              direct_mode_enable,
  input  wire logic [1:0]        led_channel_select,
  output logic      [9:0]        switch6_current_code,
  output logic      [4:0]        undervoltage_threshold_trim,
  output logic                   measure_frontend_enable,
  output logic                   measure_calibration_disable,
  output logic      [1:0]        measure_gain,
  output logic      [3:0]        measure_input_select,
  output logic      [2:0]        switch_on,
  output logic                   changeover_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.
  // A narrower address bus could not reach the upper registers.
  if (ADDR_W < MIN_ADDR_W)
  begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end
  if (DELAY_BASE < 1 || DELAY_STEP < 0)
  begin : g_delay_check
    $error("changeover delay timing must be positive");
  end

  // Registers sit one to an aligned 32-bit word, at four times their index.
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'(idx) << ADDR_SHIFT;
  endfunction : byte_addr

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [1:0]  cur_high_q, cur_high_d;
  logic [7:0]  cur_low_q, cur_low_d;
  logic [7:0]  direct_q, direct_d;
  logic [7:0]  measure_q, measure_d;
  logic [7:0]  delay_q, delay_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire hit_high    = (paddr == byte_addr(IDX_CUR_HIGH));
  wire hit_low     = (paddr == byte_addr(IDX_CUR_LOW));
  wire hit_direct  = (paddr == byte_addr(IDX_DIRECT));
  wire hit_measure = (paddr == byte_addr(IDX_MEASURE));
  wire hit_delay   = (paddr == byte_addr(IDX_DELAY));
  wire hit_any     = hit_high | hit_low | hit_direct | hit_measure | hit_delay;

  wire setup_phase = psel & ~penable;
  // [RQ9] commit at access end
  wire access_done = psel & penable & pready_q;
  wire wr_commit   = access_done & pwrite & ~pslverr_q;
  // A refused write never lands, so an unmapped offset cannot alias onto a register.

  // Read data mux; narrow registers sit in the low bits with zeros above.
  wire [7:0] rd_byte =
    hit_high    ? {6'h00, cur_high_q} :
    hit_low     ? cur_low_q :
    hit_direct  ? direct_q :
    hit_measure ? measure_q :
    hit_delay   ? delay_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: registered in the setup cycle, so every access has zero wait states.
  // The trade-off is that paddr must be settled at the setup edge, which the bus already demands.
  always_comb
  begin
    pready_d  = setup_phase;
    pslverr_d = setup_phase & ~hit_any;
    prdata_d  = prdata_q;
    if (setup_phase)
    begin
      prdata_d = (!pwrite && hit_any) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates.
  // The decode is one-hot, so the order of the else-if chain gives no priority.
  always_comb
  begin
    cur_high_d = cur_high_q;
    cur_low_d  = cur_low_q;
    direct_d   = direct_q;
    measure_d  = measure_q;
    delay_d    = delay_q;
    if (wr_commit)
    begin
      // [RQ2] high current bits
      if (hit_high)
      begin
        cur_high_d = pwdata[CUR_HIGH_MSB:0];
      end
      // [RQ1] low current byte
      else if (hit_low)
      begin
        cur_low_d = pwdata[7:0];
      end
      // [RQ5] direct and trim
      else if (hit_direct)
      begin
        direct_d = pwdata[7:0];
      end
      // [RQ6] measurement controls
      else if (hit_measure)
      begin
        measure_d = pwdata[7:0];
      end
      // [RQ7] changeover delay
      else if (hit_delay)
      begin
        delay_d = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_high_q <= CUR_HIGH_RESET;
      cur_low_q  <= REG_RESET;
      direct_q   <= REG_RESET;
      measure_q  <= REG_RESET;
      delay_q    <= REG_RESET;
    end
    else if (ce)
    begin
      cur_high_q <= cur_high_d;
      cur_low_q  <= cur_low_d;
      direct_q   <= direct_d;
      measure_q  <= measure_d;
      delay_q    <= delay_d;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; each bit is a register bit, so no decode glitch reaches the analog side.
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // [RQ3] full code range
  assign switch6_current_code        = {cur_high_q, cur_low_q};
  assign undervoltage_threshold_trim = direct_q[TRIM_MSB:0];
  assign measure_frontend_enable     = measure_q[MEAS_EN_BIT];
  assign measure_calibration_disable = measure_q[CAL_DIS_BIT];
  assign measure_gain                = measure_q[GAIN_MSB:GAIN_LSB];
  assign measure_input_select        = measure_q[SEL_MSB:0];

  ////////////////////////////////////////////////////////////////////////////
  // Changeover sequencer.
  switch_changeover #(
    .DELAY_BASE (DELAY_BASE),
    .DELAY_STEP (DELAY_STEP)
  ) u_changeover (
    .clk                (clk),
    .resetn             (resetn),
    .ce                 (ce),
    .led_channel_select (led_channel_select),
    .direct_mode_enable (direct_mode_enable),
    .direct_bits        (direct_q[DIRECT_MSB:DIRECT_LSB]),
    .delay_code         (delay_q),
    .switch_on          (switch_on),
    .changeover_busy    (changeover_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_low_byte_write: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
    (ce && wr_commit && hit_low) |=> (switch6_current_code[7:0] == $past(pwdata[7:0])))
    else $error("low current byte not stored");

  a_high_bits_join: assert property (@(posedge clk) disable iff (!resetn) // [RQ2]
    (ce && wr_commit && hit_high) |=>
      (switch6_current_code[9:8] == $past(pwdata[1:0])) && $stable(switch6_current_code[7:0]))
    else $error("high current bits not joined");

  a_code_unclamped: assert property (@(posedge clk) disable iff (!resetn) // [RQ3]
    (ce && wr_commit && hit_low && switch6_current_code[9:8] == CUR_CODE_MAX[9:8]) |=>
      (switch6_current_code == {CUR_CODE_MAX[9:8], $past(pwdata[7:0])}))
    else $error("current code altered");

  a_trim_field: assert property (@(posedge clk) disable iff (!resetn) // [RQ5]
    (ce && wr_commit && hit_direct) |=> (undervoltage_threshold_trim == $past(pwdata[4:0])))
    else $error("trim field not stored");

  a_measure_fields: assert property (@(posedge clk) disable iff (!resetn) // [RQ6]
    (ce && wr_commit && hit_measure) |=>
      (measure_frontend_enable == $past(pwdata[7])) && (measure_gain == $past(pwdata[5:4]))
      && (measure_input_select == $past(pwdata[3:0])) && (measure_calibration_disable == $past(pwdata[6])))
    else $error("measurement fields not stored");

  a_delay_readback: assert property (@(posedge clk) disable iff (!resetn) // [RQ7]
    (ce && setup_phase && !pwrite && hit_delay) |=> (prdata[7:0] == $past(delay_q)))
    else $error("delay register read back wrong");

  a_read_last: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    (access_done && !pwrite && hit_measure && !$past(wr_commit)) |-> (prdata[7:0] == measure_q))
    else $error("read does not return last written value");

  a_no_early_write: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    (ce && setup_phase && pwrite && hit_low) |=> $stable(cur_low_q))
    else $error("write applied before access end");

  a_ready_one_cycle: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    (ce && setup_phase) |=> pready ##1 (!ce || !pready || setup_phase))
    else $error("ready timing wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Refusal, hold, read padding, store and ready checks; a register may move only at its own access edge.
  a_unmapped_error: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    (ce && setup_phase && !hit_any) |=> (pready && pslverr && (prdata == 32'h00000000)))
    else $error("unmapped access not refused");

  a_refused_write: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    (access_done && pwrite && pslverr_q) |=>
      ($stable(switch6_current_code) && $stable(direct_q) && $stable(measure_q) && $stable(delay_q)))
    else $error("refused write changed a register");

  a_upper_lanes_zero: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    pready |-> (prdata[31:8] == 24'h000000))
    else $error("read data above the low byte not zero");

  a_high_read_pad: assert property (@(posedge clk) disable iff (!resetn) // [RQ2]
    (ce && setup_phase && !pwrite && hit_high) |=>
      ((prdata[7:2] == 6'h00) && (prdata[1:0] == $past(cur_high_q))))
    else $error("high current bits read back wrong");

  a_code_held: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    !(ce && wr_commit) |=> $stable(switch6_current_code))
    else $error("current code moved without a write");

  a_trim_held: assert property (@(posedge clk) disable iff (!resetn) // [RQ5]
    (ce && wr_commit && !hit_direct) |=> $stable(undervoltage_threshold_trim))
    else $error("trim field moved without its own write");

  a_measure_held: assert property (@(posedge clk) disable iff (!resetn) // [RQ6]
    (ce && wr_commit && !hit_measure) |=> $stable(measure_q))
    else $error("measurement controls moved without their own write");

  a_cur_low_held: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
    (ce && wr_commit && !hit_low) |=> $stable(cur_low_q))
    else $error("low current byte moved without its own write");

  a_delay_stored: assert property (@(posedge clk) disable iff (!resetn) // [RQ7]
    (ce && wr_commit && hit_delay) |=> (delay_q == $past(pwdata[7:0])))
    else $error("changeover delay not stored");

  a_delay_held: assert property (@(posedge clk) disable iff (!resetn) // [RQ7]
    (ce && wr_commit && !hit_delay) |=> $stable(delay_q))
    else $error("changeover delay moved without its own write");

  a_ready_needs_setup: assert property (@(posedge clk) disable iff (!resetn) // [RQ9]
    (ce && !setup_phase) |=> !pready)
    else $error("ready raised without a setup cycle");

endmodule : led_switch_control_regs

//--- tb_led_switch_control_regs.sv
// Self-checking testbench for the LED switch control register bank.
// Assumes the block answers APB with pready and drives the changeover sequencer from led_channel_select.
`timescale 1ns/1ps
module tb_led_switch_control_regs;
  import led_switch_pkg::*;

  // Short gap parameters keep the changeover runs brief; expectations derive from them.
  localparam int DBASE = 8;
  localparam int DSTEP = 4;

  logic        clk;
  logic        resetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        direct_mode_enable;
  logic [1:0]  led_channel_select;
  logic [9:0]  switch6_current_code;
  logic [4:0]  undervoltage_threshold_trim;
  logic        measure_frontend_enable;
  logic        measure_calibration_disable;
  logic [1:0]  measure_gain;
  logic [3:0]  measure_input_select;
  logic [2:0]  switch_on;
  logic        changeover_busy;
  int          n_errors;
  int          checks_done;
  logic [31:0] rd;
  logic        err;

  led_switch_control_regs #(.ADDR_W(12), .DELAY_BASE(DBASE), .DELAY_STEP(DSTEP)) u_dut (
    .clk                         (clk),
    .resetn                      (resetn),
    .ce                          (ce),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .prdata                      (prdata),
    .pready                      (pready),
    .pslverr                     (pslverr),
    .direct_mode_enable          (direct_mode_enable),
    .led_channel_select          (led_channel_select),
    .switch6_current_code        (switch6_current_code),
    .undervoltage_threshold_trim (undervoltage_threshold_trim),
    .measure_frontend_enable     (measure_frontend_enable),
    .measure_calibration_disable (measure_calibration_disable),
    .measure_gain                (measure_gain),
    .measure_input_select        (measure_input_select),
    .switch_on                   (switch_on),
    .changeover_busy             (changeover_busy)
  );

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_range

  // The request stays put until pready is sampled high; only the 80000 ns watchdog ends a wait.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err_exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, err_exp});
  endtask : rd_chk

  // Times the break and the gap of one select change; the gap follows the programmed delay code.
  task automatic change_sel(input logic [1:0] sel, input logic [2:0] on_exp, input int code);
    int n;
    int m;
    int gap;
    gap = (code == 0) ? 0 : (DBASE + (code - 1) * DSTEP + 3) / 4;
    @(posedge clk);
    led_channel_select <= sel;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (switch_on !== 3'h0 && n < 200);
    chk_range(n, 84, 111);
    if (code != 0)
      chk({31'h0, changeover_busy}, 32'h1);
    m = 0;
    do
    begin
      @(posedge clk);
      m++;
    end
    while (switch_on !== on_exp && m < 200);
    chk_range(m, gap, gap + 3);
    @(negedge clk);
    chk({31'h0, changeover_busy}, 32'h0);
  endtask : change_sel

  task automatic stop_test();
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #80000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    logic [11:0] addrs [5];
    clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    direct_mode_enable = 1'b0;
    led_channel_select = 2'h0;
    n_errors = 0;
    checks_done = 0;
    addrs = '{12'h01c, 12'h020, 12'h024, 12'h028, 12'h02c};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;

    foreach (addrs[i])
      rd_chk(addrs[i], 32'h0, 1'b0);
    chk({22'h0, switch6_current_code}, 32'h0);
    $display("test reset_values done");

    // Upper lanes and unused bits of the high current register must not stick.
    apb(12'h01c, 1'b1, 32'h1234_56ff);
    apb(12'h020, 1'b1, 32'hffff_ffff);
    apb(12'h024, 1'b1, 32'h0000_005f);
    apb(12'h028, 1'b1, 32'h0000_00a7);
    apb(12'h02c, 1'b1, 32'h0000_0002);
    @(negedge clk);
    chk({22'h0, switch6_current_code}, 32'h3ff);
    chk({27'h0, undervoltage_threshold_trim}, 32'h1f);
    chk({31'h0, measure_frontend_enable}, 32'h1);
    chk({31'h0, measure_calibration_disable}, 32'h0);
    chk({30'h0, measure_gain}, 32'h2);
    chk({28'h0, measure_input_select}, 32'h7);
    chk({29'h0, switch_on}, 32'h0);
    rd_chk(12'h01c, 32'h03, 1'b0);
    rd_chk(12'h020, 32'hff, 1'b0);
    rd_chk(12'h024, 32'h5f, 1'b0);
    rd_chk(12'h028, 32'ha7, 1'b0);
    rd_chk(12'h02c, 32'h02, 1'b0);
    apb(12'h020, 1'b1, 32'h0000_0000);
    @(negedge clk);
    chk({22'h0, switch6_current_code}, 32'h300);
    $display("test write_readback done");

    apb(12'h030, 1'b1, 32'h0000_0055);
    chk({31'h0, err}, 32'h1);
    rd_chk(12'h030, 32'h0, 1'b1);
    rd_chk(12'h021, 32'h0, 1'b1);
    rd_chk(12'h020, 32'h0, 1'b0);
    $display("test unmapped done");

    // The break is only visible while a switch is lit, so switch 4 is lit first.
    @(posedge clk);
    led_channel_select <= 2'h1;
    repeat (100) @(posedge clk);
    chk({29'h0, switch_on}, 32'h1);
    change_sel(2'h2, 3'h2, 2);
    change_sel(2'h1, 3'h1, 2);
    apb(12'h02c, 1'b1, 32'h0000_0000);
    change_sel(2'h3, 3'h4, 0);
    $display("test changeover done");

    apb(12'h024, 1'b1, 32'h0000_00a0);
    @(posedge clk);
    direct_mode_enable <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({29'h0, switch_on}, 32'h5);
    apb(12'h024, 1'b1, 32'h0000_0040);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({29'h0, switch_on}, 32'h2);
    chk({27'h0, undervoltage_threshold_trim}, 32'h0);
    rd_chk(12'h024, 32'h40, 1'b0);
    $display("test direct_mode done");

    // A low clock enable must freeze the switches even when direct mode drops.
    @(posedge clk);
    ce                 <= 1'b0;
    direct_mode_enable <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({29'h0, switch_on}, 32'h2);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({29'h0, switch_on}, 32'h4);
    $display("test clock_enable done");

    stop_test();
  end

endmodule : tb_led_switch_control_regs
